// file: include/vps_defs.svh
/*
 * Constants of the video DMA program sequencer: register offsets, reset
 * values, instruction field positions, opcodes and FIFO status codes.
 * Assumes inclusion by bare name from any file that needs them.
 */
`ifndef VPS_DEFS_SVH
`define VPS_DEFS_SVH

// Register byte offsets.
`define VPS_REG_CTRL 8'h00
`define VPS_REG_START 8'h04
`define VPS_REG_PC 8'h08
`define VPS_REG_STAT 8'h0C

// Reset values.
`define VPS_RST_WORD 32'h0000_0000
`define VPS_RST_STAT 4'h0

// Control bit positions.
`define VPS_CTRL_RUN 0

// Instruction word fields.
`define VPS_F_OP_HI 31
`define VPS_F_OP_LO 28
`define VPS_F_CNT_HI 11
`define VPS_F_BE_HI 15
`define VPS_F_BE_LO 12
`define VPS_F_CLR_HI 19
`define VPS_F_CLR_LO 16
`define VPS_F_SET_HI 23
`define VPS_F_SET_LO 20
`define VPS_F_IRQ 24
`define VPS_F_LINE_END 26
`define VPS_F_CODE_HI 3

// Opcodes.
`define VPS_OP_STORE 4'h1
`define VPS_OP_CONT 4'h5
`define VPS_OP_PLANAR 4'h9
`define VPS_OP_SYNC 4'h8
`define VPS_OP_JUMP 4'h7

// Words that follow the first word of each instruction.
`define VPS_LEN_STORE 3'h1
`define VPS_LEN_PLANAR 3'h4
`define VPS_LEN_JUMP 3'h1
`define VPS_LEN_ONE 3'h0

// FIFO status codes; a line-end code has its two top bits set.
`define VPS_CODE_PACKED 4'h1
`define VPS_CODE_PLANAR 4'h3
`define VPS_CODE_EVEN 4'h4
`define VPS_CODE_ODD 4'h5
`define VPS_CODE_LINE_END 2'h3

// Widths and steps.
`define VPS_CNT_W 12
`define VPS_STEP 32'h0000_0004

`endif

// file: include/vps_pkg.sv
/*
 * Types of the video DMA program sequencer.
 * Assumes nothing of its surroundings.
 */
package vps_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_FETCH,
        ST_EXEC,
        ST_WAIT,
        ST_SYNC,
        ST_DONE
    } vps_state_t;

endpackage

// file: include/vps_lane_if.sv
/*
 * Carrier between the sequencer and one store lane.
 * Assumes the sequencer drives the seq side and a lane the lane side.
 */
`timescale 1ns/100ps
`include "vps_defs.svh"

interface vps_lane_if;
    logic load;
    logic [31:0] addr;
    logic [`VPS_CNT_W-1:0] cnt;
    logic [3:0] be_mask;
    logic line_end_en;
    logic valid;
    logic [31:0] data;
    logic [3:0] code;
    logic grant;
    logic busy;
    logic req;
    logic take;
    logic [31:0] req_addr;
    logic [31:0] req_data;
    logic [3:0] req_be;

    modport lane (
        input load, addr, cnt, be_mask, line_end_en, valid, data, code, grant,
        output busy, req, take, req_addr, req_data, req_be
    );
    modport seq (
        output load, addr, cnt, be_mask, line_end_en, valid, data, code, grant,
        input busy, req, take, req_addr, req_data, req_be
    );
endinterface

// file: src/vps_lane.sv
/*
 * One store lane: drains one pixel FIFO into consecutive memory words.
 * Assumes the FIFO drops its head on the pop that follows take by a cycle.
 */
`timescale 1ns/100ps
`include "vps_defs.svh"

module vps_lane #(
    parameter int CNT_W = `VPS_CNT_W
) (
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    vps_lane_if.lane ln
);

    logic [31:0] addr_r;
    logic [31:0] data_r;
    logic [CNT_W-1:0] cnt_r;
    logic [3:0] be_r;
    logic busy_r;
    logic hold_r;
    logic last_r;

    wire full_w = cnt_r >= CNT_W'(4);
    wire [3:0] cnt_sh_w = (4'h1 << cnt_r[1:0]) - 4'h1;
    wire [3:0] cnt_be_w = full_w ? 4'hF : cnt_sh_w;
    wire line_end_w = ln.line_end_en && (ln.code[3:2] == `VPS_CODE_LINE_END);
    wire [4:0] end_sh_w = (5'h02 << ln.code[1:0]) - 5'h01;
    wire [3:0] end_be_w = line_end_w ? end_sh_w[3:0] : 4'hF;
    wire take_w = busy_r && !hold_r && ln.valid;

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            addr_r <= `VPS_RST_WORD;
            data_r <= `VPS_RST_WORD;
            cnt_r <= '0;
            be_r <= 4'h0;
            busy_r <= 1'b0;
            hold_r <= 1'b0;
            last_r <= 1'b0;
        end else if (ln.load) begin
            addr_r <= ln.addr;
            cnt_r <= ln.cnt;
            busy_r <= ln.cnt != '0;
            hold_r <= 1'b0;
        end else if (take_w) begin
            data_r <= ln.data;
            be_r <= ln.be_mask & cnt_be_w & end_be_w;
            cnt_r <= full_w ? cnt_r - CNT_W'(4) : '0;
            last_r <= line_end_w || (cnt_r <= CNT_W'(4));
            hold_r <= 1'b1;
        end else if (ln.grant) begin
            hold_r <= 1'b0;
            addr_r <= addr_r + `VPS_STEP;
            busy_r <= !last_r;
        end
    end

    assign ln.busy = busy_r;
    assign ln.req = hold_r;
    assign ln.take = take_w;
    assign ln.req_addr = addr_r;
    assign ln.req_data = data_r;
    assign ln.req_be = be_r;

    a_line_end_bytes: assert property (
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        take_w && line_end_w && full_w && ln.be_mask == 4'hF && !ln.load
        |=> be_r == $past(end_sh_w[3:0]) && last_r)
        else $error("Line-end code did not set the valid bytes.");

endmodule // vps_lane

// file: src/vps_ahb_regs.sv
/*
 * AHB-Lite register slave of the sequencer: control, start address,
 * program counter and status. Assumes single word transfers.
 */
`timescale 1ns/100ps
`include "vps_defs.svh"

module vps_ahb_regs (
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic run_o,
    output logic [31:0] start_o,
    input wire logic [31:0] pc_i,
    input wire logic [31:0] stat_i
);

    logic [7:0] waddr_r;
    logic wen_r;
    logic run_r;
    logic [31:0] start_r;
    logic [31:0] rdata_r;
    logic ready_r;
    logic resp_r;

    wire word_w = hsize_i == 3'h2;
    wire sel_w = hsel_i && htrans_i[1] && hready_i && word_w;
    wire [7:0] a_w = haddr_i[7:0];
    wire hi_ok_w = haddr_i[31:8] == 24'h00_0000;
    wire [31:0] rmux_w =
        !hi_ok_w ? 32'h0000_0000 :
        a_w == `VPS_REG_CTRL ? {31'h0000_0000, run_r} :
        a_w == `VPS_REG_START ? start_r :
        a_w == `VPS_REG_PC ? pc_i :
        a_w == `VPS_REG_STAT ? stat_i : 32'h0000_0000;

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wen_r <= 1'b0;
            waddr_r <= 8'h00;
            rdata_r <= `VPS_RST_WORD;
            ready_r <= 1'b1;
            resp_r <= 1'b0;
        end else begin
            wen_r <= sel_w && hwrite_i && hi_ok_w;
            waddr_r <= a_w;
            if (sel_w && !hwrite_i) begin
                rdata_r <= rmux_w;
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            run_r <= 1'b0;
            start_r <= `VPS_RST_WORD;
        end else if (wen_r && waddr_r == `VPS_REG_CTRL) begin
            run_r <= hwdata_i[`VPS_CTRL_RUN];
        end else if (wen_r && waddr_r == `VPS_REG_START) begin
            start_r <= hwdata_i;
        end
    end

    assign hrdata_o = rdata_r;
    assign hreadyout_o = ready_r;
    assign hresp_o = resp_r;
    assign run_o = run_r;
    assign start_o = start_r;

endmodule // vps_ahb_regs

// file: src/vps_sequencer.sv
/*
 * Program sequencer of a video capture DMA engine: fetches instructions
 * from host memory, decodes stores, markers and branches, and drains the
 * three pixel FIFOs into memory writes. Assumes the fetch port, the FIFOs
 * and the write port all run on ref_clk_i.
 */
// The implementer's own choices: the register offsets and the AHB-Lite slave port.
`timescale 1ns/100ps
`include "vps_defs.svh"

module vps_sequencer (
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic fetch_req_o,
    output logic [31:0] fetch_addr_o,
    input wire logic fetch_ack_i,
    input wire logic [31:0] fetch_data_i,
    input wire logic [2:0] fifo_valid_i,
    input wire logic [95:0] fifo_data_i,
    input wire logic [11:0] fifo_code_i,
    output logic [2:0] fifo_pop_o,
    output logic wr_valid_o,
    output logic [31:0] wr_addr_o,
    output logic [31:0] wr_data_o,
    output logic [3:0] wr_be_o,
    input wire logic wr_ready_i,
    output logic irq_o
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations.

    vps_pkg::vps_state_t state_r;
    vps_pkg::vps_state_t state_nxt;
    logic [31:0] word_r [0:4];
    logic [2:0] idx_r;
    logic [2:0] need_r;
    logic [31:0] pc_r;
    logic fetch_req_r;
    logic planar_r;
    logic [3:0] pstat_r;
    logic irq_r;
    logic [2:0] pop_r;
    logic wr_valid_r;
    logic [31:0] wr_addr_r;
    logic [31:0] wr_data_r;
    logic [3:0] wr_be_r;
    logic run_w;
    logic [31:0] start_w;
    logic [31:0] stat_w;
    logic [2:0] load_w;
    logic [2:0] busy_w;
    logic [2:0] req_w;
    logic [2:0] take_w;
    logic [2:0] grant_w;
    logic [31:0] ld_addr_w [0:2];
    logic [`VPS_CNT_W-1:0] ld_cnt_w [0:2];
    logic [31:0] raddr_w [0:2];
    logic [31:0] rdata_w [0:2];
    logic [3:0] rbe_w [0:2];

    function automatic logic [2:0] vps_len(input logic [3:0] op);
        unique case (op)
            `VPS_OP_STORE: vps_len = `VPS_LEN_STORE;
            `VPS_OP_PLANAR: vps_len = `VPS_LEN_PLANAR;
            `VPS_OP_JUMP: vps_len = `VPS_LEN_JUMP;
            default: vps_len = `VPS_LEN_ONE;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Register file.

    vps_ahb_regs u_regs (
        .ref_clk_i(ref_clk_i),
        .reset_n_i(reset_n_i),
        .hsel_i(hsel_i),
        .haddr_i(haddr_i),
        .htrans_i(htrans_i),
        .hwrite_i(hwrite_i),
        .hsize_i(hsize_i),
        .hwdata_i(hwdata_i),
        .hready_i(hready_i),
        .hrdata_o(hrdata_o),
        .hreadyout_o(hreadyout_o),
        .hresp_o(hresp_o),
        .run_o(run_w),
        .start_o(start_w),
        .pc_i(pc_r),
        .stat_i(stat_w)
    );

    assign stat_w = {26'h000_0000, state_r != vps_pkg::ST_IDLE,
                     planar_r, pstat_r};

    ////////////////////////////////////////////////////////////////////////
    // Decode.

    wire [3:0] op_w = word_r[0][`VPS_F_OP_HI:`VPS_F_OP_LO];
    wire [3:0] clr_w = word_r[0][`VPS_F_CLR_HI:`VPS_F_CLR_LO];
    wire [3:0] set_w = word_r[0][`VPS_F_SET_HI:`VPS_F_SET_LO];
    wire [3:0] want_w = word_r[0][`VPS_F_CODE_HI:0];
    wire [31:0] word1_w = word_r[1];
    wire [31:0] word2_w = word_r[2];
    wire [31:0] word3_w = word_r[3];
    wire [31:0] word4_w = word_r[4];
    wire is_store_w = op_w == `VPS_OP_STORE;
    wire is_cont_w = op_w == `VPS_OP_CONT;
    wire is_planar_w = op_w == `VPS_OP_PLANAR;
    wire is_sync_w = op_w == `VPS_OP_SYNC;
    wire is_jump_w = op_w == `VPS_OP_JUMP;
    wire fetch_w = state_r == vps_pkg::ST_FETCH;
    wire exec_w = state_r == vps_pkg::ST_EXEC;
    wire done_w = state_r == vps_pkg::ST_DONE;
    wire ack_w = fetch_w && fetch_ack_i;
    wire [3:0] new_op_w = fetch_data_i[`VPS_F_OP_HI:`VPS_F_OP_LO];
    wire [2:0] need_w = (idx_r == 3'h0) ? vps_len(new_op_w) : need_r;
    wire last_w = ack_w && idx_r == need_w;
    wire drained_w = busy_w == 3'h0 && !wr_valid_r;

    // Marker: discard first-FIFO words until the expected code arrives.
    wire [3:0] code0_w = fifo_code_i[3:0];
    wire sync_take_w = state_r == vps_pkg::ST_SYNC
                       && fifo_valid_i[0] && !pop_r[0];
    wire sync_hit_w = sync_take_w && code0_w == want_w;

    ////////////////////////////////////////////////////////////////////////
    // Store lanes.

    assign load_w[0] = exec_w && (is_store_w || is_cont_w || is_planar_w);
    assign load_w[1] = exec_w && is_planar_w;
    assign load_w[2] = exec_w && is_planar_w;
    assign ld_addr_w[0] = is_cont_w ? raddr_w[0] :
                          (is_planar_w ? word2_w : word1_w);
    assign ld_addr_w[1] = word3_w;
    assign ld_addr_w[2] = word4_w;
    assign ld_cnt_w[0] = word_r[0][`VPS_F_CNT_HI:0];
    assign ld_cnt_w[1] = word1_w[`VPS_F_CNT_HI:0];
    assign ld_cnt_w[2] = word1_w[`VPS_F_CNT_HI:0];

    vps_lane_if ln_if [0:2] ();

    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : g_lane
            assign ln_if[g].load = load_w[g];
            assign ln_if[g].addr = ld_addr_w[g];
            assign ln_if[g].cnt = ld_cnt_w[g];
            assign ln_if[g].be_mask = word_r[0][`VPS_F_BE_HI:`VPS_F_BE_LO];
            assign ln_if[g].line_end_en = word_r[0][`VPS_F_LINE_END];
            assign ln_if[g].valid = fifo_valid_i[g];
            assign ln_if[g].data = fifo_data_i[32*g +: 32];
            assign ln_if[g].code = fifo_code_i[4*g +: 4];
            assign ln_if[g].grant = grant_w[g];
            assign busy_w[g] = ln_if[g].busy;
            assign req_w[g] = ln_if[g].req;
            assign take_w[g] = ln_if[g].take;
            assign raddr_w[g] = ln_if[g].req_addr;
            assign rdata_w[g] = ln_if[g].req_data;
            assign rbe_w[g] = ln_if[g].req_be;
            vps_lane #(
                .CNT_W(`VPS_CNT_W)
            ) u_lane (
                .ref_clk_i(ref_clk_i),
                .reset_n_i(reset_n_i),
                .ln(ln_if[g])
            );
        end
    endgenerate

    // Fixed priority: luma first, then the two chroma lanes.
    assign grant_w[0] = !wr_valid_r && req_w[0];
    assign grant_w[1] = !wr_valid_r && req_w[1] && !req_w[0];
    assign grant_w[2] = !wr_valid_r && req_w[2] && !(|req_w[1:0]);
    wire [1:0] gsel_w = req_w[0] ? 2'h0 : (req_w[1] ? 2'h1 : 2'h2);

    ////////////////////////////////////////////////////////////////////////
    // Sequencer state machine.

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            vps_pkg::ST_IDLE: if (run_w) state_nxt = vps_pkg::ST_FETCH;
            vps_pkg::ST_FETCH: if (last_w) state_nxt = vps_pkg::ST_EXEC;
            vps_pkg::ST_EXEC: begin
                if (is_sync_w) begin
                    state_nxt = vps_pkg::ST_SYNC;
                end else if (load_w[0]) begin
                    state_nxt = vps_pkg::ST_WAIT;
                end else begin
                    state_nxt = vps_pkg::ST_DONE;
                end
            end
            vps_pkg::ST_WAIT: if (drained_w) state_nxt = vps_pkg::ST_DONE;
            vps_pkg::ST_SYNC: begin
                if (!run_w) begin
                    state_nxt = vps_pkg::ST_IDLE;
                end else if (sync_hit_w) begin
                    state_nxt = vps_pkg::ST_DONE;
                end
            end
            vps_pkg::ST_DONE: begin
                state_nxt = run_w ? vps_pkg::ST_FETCH : vps_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_r <= vps_pkg::ST_IDLE;
            fetch_req_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            fetch_req_r <= state_nxt == vps_pkg::ST_FETCH;
        end
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pc_r <= `VPS_RST_WORD;
        end else if (state_r == vps_pkg::ST_IDLE && run_w) begin
            pc_r <= start_w;
        end else if (ack_w) begin
            pc_r <= pc_r + `VPS_STEP;
        end else if (exec_w && is_jump_w) begin
            pc_r <= word1_w;
        end
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            for (int i = 0; i < 5; i++) begin
                word_r[i] <= `VPS_RST_WORD;
            end
            idx_r <= 3'h0;
            need_r <= 3'h0;
        end else if (ack_w) begin
            word_r[idx_r] <= fetch_data_i;
            need_r <= need_w;
            idx_r <= last_w ? 3'h0 : idx_r + 3'h1;
        end
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            planar_r <= 1'b0;
        end else if (sync_hit_w && code0_w == `VPS_CODE_PLANAR) begin
            planar_r <= 1'b1;
        end else if (sync_hit_w && code0_w == `VPS_CODE_PACKED) begin
            planar_r <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pstat_r <= `VPS_RST_STAT;
            irq_r <= 1'b0;
        end else begin
            irq_r <= done_w && word_r[0][`VPS_F_IRQ];
            if (done_w) begin
                pstat_r <= (pstat_r & ~clr_w) | set_w;
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pop_r <= 3'h0;
        end else begin
            pop_r <= take_w | {2'h0, sync_take_w};
        end
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wr_valid_r <= 1'b0;
            wr_addr_r <= `VPS_RST_WORD;
            wr_data_r <= `VPS_RST_WORD;
            wr_be_r <= 4'h0;
        end else if (wr_valid_r && wr_ready_i) begin
            wr_valid_r <= 1'b0;
        end else if (|grant_w) begin
            wr_valid_r <= 1'b1;
            wr_addr_r <= raddr_w[gsel_w];
            wr_data_r <= rdata_w[gsel_w];
            wr_be_r <= rbe_w[gsel_w];
        end
    end

    assign fetch_req_o = fetch_req_r;
    assign fetch_addr_o = pc_r;
    assign fifo_pop_o = pop_r;
    assign wr_valid_o = wr_valid_r;
    assign wr_addr_o = wr_addr_r;
    assign wr_data_o = wr_data_r;
    assign wr_be_o = wr_be_r;
    assign irq_o = irq_r;

    ////////////////////////////////////////////////////////////////////////
    // Assertions.

    a_fetch_hold: assert property (
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        fetch_req_o && !fetch_ack_i |=> fetch_req_o && $stable(fetch_addr_o))
        else $error("Fetch request dropped or moved before its answer.");

    a_fetch_len: assert property (
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        $rose(exec_w) |-> need_r == vps_len(op_w) && idx_r == 3'h0)
        else $error("Instruction length does not match its opcode.");

    a_jump_target: assert property (
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        exec_w && is_jump_w |=> pc_r == $past(word1_w) ##1 fetch_req_o)
        else $error("Branch did not resume fetching at its target.");

    a_store_addr: assert property (
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        exec_w && is_store_w |=> raddr_w[0] == $past(word1_w)
        && busy_w[0] == ($past(word_r[0][`VPS_F_CNT_HI:0]) != 12'h000))
        else $error("Packed store did not load its target.");

    a_planar_addr: assert property (
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        exec_w && is_planar_w |=> raddr_w[0] == $past(word2_w)
        && raddr_w[1] == $past(word3_w) && raddr_w[2] == $past(word4_w))
        else $error("Planar store did not load its three targets.");

    a_planar_count: assert property (
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        exec_w && is_planar_w |=> busy_w[2:1]
        == {2{$past(word1_w[`VPS_F_CNT_HI:0]) != 12'h000}})
        else $error("Chroma byte count not applied to both lanes.");

    a_mode_switch: assert property (
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        sync_hit_w && code0_w == `VPS_CODE_PLANAR |=> planar_r ##1 planar_r)
        else $error("Planar code did not switch the mode.");

    a_marker_wait: assert property (
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        state_r == vps_pkg::ST_SYNC && run_w && !sync_hit_w
        |=> state_r == vps_pkg::ST_SYNC)
        else $error("Marker left before its status code arrived.");

    a_irq_pulse: assert property (
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        irq_o |-> $past(done_w) && $past(word_r[0][`VPS_F_IRQ]) ##1 !irq_o)
        else $error("Interrupt request without a flagged instruction.");

endmodule // vps_sequencer

// file: test/vps_host_mem.sv
/* Host memory model: serves the two-field program and accepts writes.
 * Assumes the sequencer's fetch and write ports on ref_clk_i. */
`timescale 1ns/100ps
module vps_host_mem (
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire logic fetch_req_i,
    input wire logic [31:0] fetch_addr_i,
    output logic fetch_ack_o,
    output logic [31:0] fetch_data_o,
    output logic wr_ready_o
);
    logic [31:0] word;
    always_comb begin
        case (fetch_addr_i)
            32'h0000_0100: word = 32'h8000_0001;
            32'h0000_0104: word = 32'h1101_F008;
            32'h0000_0108: word = 32'h0000_0200;
            32'h0000_010C: word = 32'h8000_0004;
            32'h0000_0110: word = 32'h8000_0003;
            32'h0000_0114: word = 32'h9450_F010;
            32'h0000_0118: word = 32'h0000_0004;
            32'h0000_011C: word = 32'h0000_0300;
            32'h0000_0120: word = 32'h0000_0400;
            32'h0000_0124: word = 32'h0000_0500;
            32'h0000_0128: word = 32'h8000_0005;
            32'h0000_012C: word = 32'h7000_0000;
            default: word = 32'h0000_0100;
        endcase
    end
    assign fetch_data_o = fetch_ack_o ? word : ~word;
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            fetch_ack_o <= 1'h0;
            wr_ready_o <= 1'h0;
        end else begin
            fetch_ack_o <= fetch_req_i && !fetch_ack_o && $urandom_range(1);
            wr_ready_o <= 1'($urandom_range(1));
        end
    end
endmodule // vps_host_mem

// file: test/tb.sv
/* Testbench: loops a two-field program over packed and planar streams.
 * Assumes the host memory model answers fetches and writes. */
`timescale 1ns/100ps
module tb;
    logic ref_clk_i = 1'h0;
    logic reset_n_i = 1'h0;
    logic hsel = 1'h0;
    logic hwrite = 1'h0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, f_addr, f_data, w_addr, w_data, r, d[8];
    logic hrdy, hresp, f_req, f_ack, w_val, w_rdy, irq;
    logic [2:0] pop;
    logic [3:0] w_be;
    logic [67:0] q[$];
    int k = 0;
    int n_fail = 0;
    int cmp_count = 0;
    int n_irq = 0;
    int n_top = 0;
    int n_cb = 0;
    wire logic [3:0] code = 4'(28'h5D3_4001 >> (4 * (k % 7)));
    always #4 ref_clk_i = ~ref_clk_i;
    vps_sequencer DUT (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
        .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
        .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hrdy),
        .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(hresp),
        .fetch_req_o(f_req), .fetch_addr_o(f_addr), .fetch_ack_i(f_ack),
        .fetch_data_i(f_data), .fifo_valid_i({3{k < 21}}),
        .fifo_data_i({d[7], d[6], d[k % 7]}), .fifo_code_i({8'h0, code}),
        .fifo_pop_o(pop), .wr_valid_o(w_val), .wr_addr_o(w_addr),
        .wr_data_o(w_data), .wr_be_o(w_be), .wr_ready_i(w_rdy), .irq_o(irq));
    vps_host_mem mem (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
        .fetch_req_i(f_req), .fetch_addr_i(f_addr), .fetch_ack_o(f_ack),
        .fetch_data_o(f_data), .wr_ready_o(w_rdy));
    task automatic chk(input logic [67:0] e, input logic [67:0] g);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
        hsel <= 1'h1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        @(posedge ref_clk_i);
        while (!hrdy) @(posedge ref_clk_i);
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge ref_clk_i);
        while (!hrdy) @(posedge ref_clk_i);
        r = hrdata;
        chk(68'h0, 68'(hresp));
    endtask
    task print_verdict;
        $display("Checks %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge ref_clk_i) begin
        if (reset_n_i && pop[0] && (k % 7 == 1 || k % 7 == 2))
            q.push_back({32'h1FC + 32'(4 * (k % 7)), d[k % 7], 4'hF});
        if (reset_n_i && pop[0] && k % 7 == 5) begin
            q.push_back({32'h300, d[5], 4'h3});
            q.push_back({32'h400, d[6], 4'hF});
            q.push_back({32'h500, d[7], 4'hF});
        end
        if (reset_n_i && w_val && w_rdy)
            chk(q.pop_front(), {w_addr, w_data, w_be});
        n_irq += (irq === 1'h1);
        n_cb += int'(pop[1] === 1'h1) + int'(pop[2] === 1'h1);
        n_top += (f_ack && f_req && f_addr === 32'h100);
        k <= k + int'(pop[0] === 1'h1);
    end
    initial begin
        #160000;
        n_fail++;
        print_verdict;
    end
    initial begin
        void'($urandom(32'hEC8A));
        foreach (d[i]) d[i] = $urandom;
        repeat (3) @(posedge ref_clk_i);
        reset_n_i <= 1'h1;
        ahb(1'h1, 32'h04, 32'h100);
        ahb(1'h0, 32'h04, 32'h0);
        chk(68'h100, 68'(r));
        ahb(1'h0, 32'h10, 32'h0);
        chk(68'h0, 68'(r));
        ahb(1'h1, 32'h00, 32'h1);
        for (int i = 0; i < 5000 && k < 21; i++) @(posedge ref_clk_i);
        repeat (60) @(posedge ref_clk_i);
        chk(68'd21, 68'(k));
        chk(68'd3, 68'(n_irq));
        chk(68'd4, 68'(n_top));
        chk(68'd6, 68'(n_cb));
        chk(68'd0, 68'(q.size()));
        ahb(1'h0, 32'h0C, 32'h0);
        chk(68'h35, 68'(r));
        ahb(1'h0, 32'h08, 32'h0);
        chk(68'h104, 68'(r));
        print_verdict;
    end
endmodule // tb
